// File: core/char_glyph_if.sv
// Interface carrying one decoded glyph from the decoder to the output stage.
`timescale 1ns/10ps
interface char_glyph_if;
  import char_set_pkg::*;
  logic valid;
  logic [7:0] code;
  charSet_t set;
  logic parityError;
  modport src (output valid, output code, output set, output parityError);
  modport dst (input valid, input code, input set, input parityError);
endinterface : char_glyph_if

// File: core/char_set_cfg.svh
// Constants for the character set and parity selection block.
// Function
// - Both switches off: no parity check, shift codes ignored, bit eight picks set.
// - Mode switch only: no parity check, bit eight ignored, last shift code picks set.
// - Parity switch only: check even parity, shift-in normal, shift-out alternate.
// - Both switches on: check odd parity, shift codes still pick the set.
// - A parity failure outputs the error symbol whatever set is active.
// - Self-test pattern is normal set with parity switch on, else alternate.
// - With the dual set fitted, tab and set-tab-stops sequence are discarded.
// - Special alternate variant substitutes six glyphs for codes 61 through 66.
// - Normal set: 64 standard plus 31 optional; alternate: 64 Katakana plus 31 ASCII.
`ifndef CHAR_SET_CFG_SVH
`define CHAR_SET_CFG_SVH
`define CODE_SHIFT_OUT 7'h0E
`define CODE_SHIFT_IN 7'h0F
`define CODE_HTAB 7'h09
`define CODE_ESC 7'h1B
`define CODE_TAB_SET 7'h33
`define CODE_SUB_FIRST 7'h61
`define CODE_SUB_LAST 7'h66
`define CODE_ERROR_SYM 8'h7F
`define CODE_SUB_BASE 8'h80
`define CODE_TEST_FIRST 7'h20
`define CODE_TEST_LAST 7'h7E
`define GLYPH_STD_COUNT 7'h40
`define GLYPH_OPT_COUNT 7'h1F
`endif

// File: core/char_set_pkg.sv
// Types for the character set and parity selection block.
package char_set_pkg;
  typedef enum logic [1:0] {
    SEL_BIT8,
    SEL_SHIFT,
    SEL_EVEN,
    SEL_ODD
  } selMode_t;
  typedef enum logic {
    SET_NORMAL,
    SET_ALTERNATE
  } charSet_t;
  typedef enum logic [1:0] {
    ESC_IDLE,
    ESC_SEEN
  } escState_t;
endpackage : char_set_pkg

// File: core/char_set_select.sv
// Character set selection, parity check, tab discard and self-test pattern source.
`timescale 1ns/10ps
`include "char_set_cfg.svh"
module char_set_select
  import char_set_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Control panel switches and option straps, held static in use.
  input wire logic panel_parity_switch,
  input wire logic panel_mode_switch,
  input wire logic dualSetFitted,
  input wire logic specialAlt,
  input wire logic selfTest,
  // Received character from the line.
  input wire logic charValid,
  input wire logic [7:0] charData,
  // Printed glyph out.
  output logic glyphValid,
  output logic [7:0] glyphCode,
  output logic glyphAlternate,
  // Status.
  output logic shiftAlternate,
  output logic tabDiscarded
);
  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire selMode_t mode = selMode_t'({panel_parity_switch, panel_mode_switch});
  wire useBit8 = mode == SEL_BIT8;
  wire checkParity = panel_parity_switch;
  // Even mode expects even ones over all eight bits; odd mode expects odd ones.
  wire parityBad = checkParity && ((^charData) != (mode == SEL_ODD));
  wire isShiftIn = charData[6:0] == `CODE_SHIFT_IN;
  wire isShiftOut = charData[6:0] == `CODE_SHIFT_OUT;

  // Shift state, normal after reset until a shift-out is seen.
  logic shift_r;
  logic shift_nxt;
  escState_t esc_r;
  escState_t esc_nxt;
  logic testOn_r;
  logic [6:0] testCode_r;
  logic discard_r;

  // ----------------------------------------------------------------
  // Shift code tracking
  // ----------------------------------------------------------------
  // Shift codes count only outside bit-eight mode, and never when their own parity fails.
  always_comb begin
    shift_nxt = shift_r;
    if (charValid && !useBit8 && !parityBad && isShiftOut) shift_nxt = 1'b1;
    if (charValid && !useBit8 && !parityBad && isShiftIn) shift_nxt = 1'b0;
  end

  // Escape tracking for the set-tab-stops sequence.
  always_comb begin
    esc_nxt = esc_r;
    if (charValid) esc_nxt = (charData[6:0] == `CODE_ESC) ? ESC_SEEN : ESC_IDLE;
  end

  wire isTabSeq = esc_r == ESC_SEEN && charData[6:0] == `CODE_TAB_SET;
  wire isTab = dualSetFitted && (charData[6:0] == `CODE_HTAB || isTabSeq);
  wire isControl = charData[6:0] < `CODE_TEST_FIRST || charData[6:0] == `CODE_ESC;
  wire isTabSetArg = esc_r == ESC_SEEN;
  // Controls, shift codes and escape pairs print nothing here; parity failures always print.
  wire printable = parityBad || (!isControl && !isTabSetArg && !isTab);

  // Registered state.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_r <= 1'b0;
      esc_r <= ESC_IDLE;
      discard_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      esc_r <= esc_nxt;
      discard_r <= charValid && isTab;
    end
  end

  // ----------------------------------------------------------------
  // Self-test pattern
  // ----------------------------------------------------------------
  // One pass covers the 64 base glyphs plus the 31 extra ones that either set holds.
  wire [6:0] testLast = `CODE_TEST_FIRST + `GLYPH_STD_COUNT + `GLYPH_OPT_COUNT - 7'h01;
  // The first code is held until the pattern is live, so no glyph of the pass is skipped.
  wire testRestart = !selfTest || !testOn_r || testCode_r == testLast;

  // The pattern walks the printable range one code per cycle, repeating while test is held.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      testOn_r <= 1'b0;
      testCode_r <= `CODE_TEST_FIRST;
    end else begin
      testOn_r <= selfTest;
      if (testRestart) testCode_r <= `CODE_TEST_FIRST;
      else testCode_r <= testCode_r + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Set choice and hand-off
  // ----------------------------------------------------------------
  wire charSet_t lineSet = useBit8 ? charSet_t'(charData[7]) : charSet_t'(shift_r);
  wire charSet_t testSet = panel_parity_switch ? SET_NORMAL : SET_ALTERNATE;

  char_glyph_if glyph ();
  assign glyph.valid = testOn_r || (charValid && printable);
  assign glyph.code = testOn_r ? {1'b0, testCode_r} : {1'b0, charData[6:0]};
  assign glyph.set = testOn_r ? testSet : lineSet;
  assign glyph.parityError = !testOn_r && parityBad;

  // Both sets hold 64 base glyphs plus 31 extra, so one 7-bit index serves each.
  glyph_out_stage outStage (
    .clk(clk),
    .rstn(rstn),
    .glyphIn(glyph),
    .specialAlt(specialAlt),
    .glyphValid(glyphValid),
    .glyphCode(glyphCode),
    .glyphAlternate(glyphAlternate)
  );

  assign shiftAlternate = shift_r;
  assign tabDiscarded = discard_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_shiftOut;
    charValid && !useBit8 && !parityBad && isShiftOut;
  endsequence
  sequence s_shiftIn;
    charValid && !useBit8 && !parityBad && isShiftIn;
  endsequence
  sequence s_badChar;
    charValid && parityBad && !testOn_r;
  endsequence
  sequence s_testStep;
    testOn_r && selfTest && testCode_r != testLast;
  endsequence
  sequence s_testWrap;
    testOn_r && selfTest && testCode_r == testLast;
  endsequence

  // ----------------------------------------------------------------
  // Checks on set selection
  // ----------------------------------------------------------------
  // The shift state must only move on an accepted shift code.
  a_bit8_select: assert property (@(posedge clk) disable iff (!rstn)
    charValid && useBit8 && printable && !testOn_r |=> glyphAlternate == $past(charData[7]))
    else $error("bit eight did not select set");
  a_bit8_keeps_shift: assert property (@(posedge clk) disable iff (!rstn)
    useBit8 |=> $stable(shiftAlternate))
    else $error("shift state moved in bit eight mode");
  a_shift_out_set: assert property (@(posedge clk) disable iff (!rstn)
    s_shiftOut |=> shiftAlternate)
    else $error("shift-out did not select alternate");
  a_shift_in_set: assert property (@(posedge clk) disable iff (!rstn)
    s_shiftIn |=> !shiftAlternate)
    else $error("shift-in did not select normal");
  a_shift_hold: assert property (@(posedge clk) disable iff (!rstn)
    !charValid |=> $stable(shiftAlternate))
    else $error("shift state moved with no character");
  a_shift_set_used: assert property (@(posedge clk) disable iff (!rstn)
    charValid && !useBit8 && printable && !parityBad && !testOn_r |=> glyphAlternate == $past(shiftAlternate))
    else $error("shift state did not pick the set");

  // ----------------------------------------------------------------
  // Checks on parity
  // ----------------------------------------------------------------
  // Both directions of each check are covered, so a stuck error flag is caught too.
  a_even_parity: assert property (@(posedge clk) disable iff (!rstn)
    charValid && mode == SEL_EVEN && (^charData) |-> parityBad)
    else $error("even parity failure missed");
  a_even_accept: assert property (@(posedge clk) disable iff (!rstn)
    charValid && mode == SEL_EVEN && !(^charData) |-> !parityBad)
    else $error("even parity character refused");
  a_odd_parity: assert property (@(posedge clk) disable iff (!rstn)
    charValid && mode == SEL_ODD |-> parityBad == !(^charData))
    else $error("odd parity check wrong");
  a_no_check: assert property (@(posedge clk) disable iff (!rstn)
    !panel_parity_switch |-> !parityBad)
    else $error("parity checked with switch off");
  a_bad_char_out: assert property (@(posedge clk) disable iff (!rstn)
    s_badChar |=> glyphValid && glyphCode == `CODE_ERROR_SYM && !glyphAlternate)
    else $error("parity failure did not print the error symbol");

  // ----------------------------------------------------------------
  // Checks on the self-test pattern
  // ----------------------------------------------------------------
  // The pattern must start at the first code and step through the whole range.
  a_test_set: assert property (@(posedge clk) disable iff (!rstn)
    testOn_r ##1 glyphValid |-> glyphAlternate == !$past(panel_parity_switch))
    else $error("self-test pattern set wrong");
  a_test_start: assert property (@(posedge clk) disable iff (!rstn)
    testOn_r && !$past(testOn_r) |-> testCode_r == `CODE_TEST_FIRST)
    else $error("self-test did not start at the first code");
  a_test_step: assert property (@(posedge clk) disable iff (!rstn)
    s_testStep |=> testCode_r == $past(testCode_r) + 7'h01)
    else $error("self-test code did not advance");
  a_test_wrap: assert property (@(posedge clk) disable iff (!rstn)
    s_testWrap |=> testCode_r == `CODE_TEST_FIRST)
    else $error("self-test did not wrap after the last glyph");
  a_test_code: assert property (@(posedge clk) disable iff (!rstn)
    testOn_r && !specialAlt |=> glyphValid && glyphCode == {1'b0, $past(testCode_r)})
    else $error("self-test glyph not printed");

  // ----------------------------------------------------------------
  // Checks on tabs and reset
  // ----------------------------------------------------------------
  // A tab with failed parity still raises tabDiscarded, but it prints the error symbol instead.
  a_tab_drop: assert property (@(posedge clk) disable iff (!rstn)
    charValid && dualSetFitted && charData[6:0] == `CODE_HTAB && !parityBad && !testOn_r |=>
      tabDiscarded && !glyphValid)
    else $error("tab not discarded");
  a_tab_seq_drop: assert property (@(posedge clk) disable iff (!rstn)
    charValid && dualSetFitted && isTabSeq && !parityBad && !testOn_r |=> tabDiscarded && !glyphValid)
    else $error("set-tab-stops sequence not discarded");
  a_tab_kept: assert property (@(posedge clk) disable iff (!rstn)
    charValid && !dualSetFitted && charData[6:0] == `CODE_HTAB |=> !tabDiscarded)
    else $error("tab discarded without the dual set");
  a_reset_normal: assert property (@(posedge clk)
    !rstn |=> !shiftAlternate)
    else $error("reset did not restore normal set");
endmodule : char_set_select

// File: core/glyph_out_stage.sv
// Output stage: error symbol and special alternate substitution, registered.
`timescale 1ns/10ps
`include "char_set_cfg.svh"
module glyph_out_stage
  import char_set_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Decoded glyph in.
  char_glyph_if.dst glyphIn,
  // Variant select.
  input wire logic specialAlt,
  // Printed glyph out.
  output logic glyphValid,
  output logic [7:0] glyphCode,
  output logic glyphAlternate
);
  // ----------------------------------------------------------------
  // Substitution decode
  // ----------------------------------------------------------------
  // Substitute glyphs live above the normal code space so they never alias.
  wire inSubRange = glyphIn.code[6:0] >= `CODE_SUB_FIRST && glyphIn.code[6:0] <= `CODE_SUB_LAST;
  wire doSub = specialAlt && glyphIn.set == SET_ALTERNATE && inSubRange;
  wire [7:0] subCode = `CODE_SUB_BASE + {1'b0, glyphIn.code[6:0] - `CODE_SUB_FIRST};
  wire [7:0] outCode = glyphIn.parityError ? `CODE_ERROR_SYM :
                       doSub ? subCode : {1'b0, glyphIn.code[6:0]};

  // Output register; the error symbol ignores the active set.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      glyphValid <= 1'b0;
      glyphCode <= 8'h00;
      glyphAlternate <= 1'b0;
    end else begin
      glyphValid <= glyphIn.valid;
      glyphCode <= outCode;
      glyphAlternate <= glyphIn.set == SET_ALTERNATE && !glyphIn.parityError;
    end
  end

  a_error_symbol: assert property (@(posedge clk) disable iff (!rstn)
    glyphIn.valid && glyphIn.parityError |=> glyphValid && glyphCode == `CODE_ERROR_SYM)
    else $error("parity error did not give error symbol");
  a_sub_range: assert property (@(posedge clk) disable iff (!rstn)
    glyphIn.valid && doSub && !glyphIn.parityError |=> glyphCode[7])
    else $error("special alternate substitution missing");
endmodule : glyph_out_stage

// File: dv/host_line_model.sv
// Host model that sends character codes to the block over the line.
`timescale 1ns/10ps
module host_line_model (
  // Clock.
  input wire logic clk,
  // Character to the block.
  output logic charValid,
  output logic [7:0] charData
);
  // The line is quiet at time zero.
  initial begin
    charValid = 1'b0;
    charData = 8'hA5;
  end

  // -----------------------------------------
  // Send one code
  // -----------------------------------------
  // Once released, the data line shows the inverse, so a stale code is never taken for a new one.
  task automatic send_char(input logic [7:0] code);
    @(posedge clk);
    charValid <= 1'b1;
    charData <= code;
    @(posedge clk);
    charValid <= 1'b0;
    charData <= ~code;
  endtask : send_char
endmodule : host_line_model

// File: dv/tb_top.sv
// Self-checking testbench for the character set and parity selection block.
`timescale 1ns/10ps
module tb_top;
  logic clk;
  logic rstn;
  logic parSw;
  logic modeSw;
  logic dualSet;
  logic subAlt;
  logic testRun;
  logic charValid;
  logic [7:0] charData;
  logic glyphValid;
  logic [7:0] glyphCode;
  logic glyphAlternate;
  logic shiftAlternate;
  logic tabDiscarded;
  int error_cnt = 0;
  int n_tests = 0;
  int cycCnt = 0;

  host_line_model u_host (.clk(clk), .charValid(charValid), .charData(charData));

  char_set_select u_dut (
    .clk(clk), .rstn(rstn), .panel_parity_switch(parSw), .panel_mode_switch(modeSw),
    .dualSetFitted(dualSet), .specialAlt(subAlt), .selfTest(testRun), .charValid(charValid),
    .charData(charData), .glyphValid(glyphValid), .glyphCode(glyphCode),
    .glyphAlternate(glyphAlternate), .shiftAlternate(shiftAlternate), .tabDiscarded(tabDiscarded)
  );

  // -----------------------------------------
  // Helpers
  // -----------------------------------------
  // Compares one value and reports a difference at once.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // Sends one code and checks the glyph one cycle later, once it has settled.
  task automatic tx(input logic [7:0] code, input logic expV, input logic [7:0] expC, input logic expA);
    u_host.send_char(code);
    @(negedge clk);
    chk({7'h00, glyphValid}, {7'h00, expV});
    if (expV) begin
      chk(glyphCode, expC);
      chk({7'h00, glyphAlternate}, {7'h00, expA});
    end
  endtask : tx

  // Switches are only moved under reset, which also clears the shift state.
  task automatic cfg(input logic par, input logic mode);
    @(posedge clk);
    parSw <= par;
    modeSw <= mode;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
  endtask : cfg

  // Clock at 100 ns, and a cycle ceiling well above the 178 cycles the tests need.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycCnt++;
    if (cycCnt == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  // -----------------------------------------
  // Main sequence
  // -----------------------------------------
  initial begin
    rstn = 1'b0;
    parSw = 1'b0;
    modeSw = 1'b0;
    dualSet = 1'b0;
    subAlt = 1'b0;
    testRun = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    tx(8'hC1, 1'b1, 8'h41, 1'b1);
    tx(8'h0E, 1'b0, 8'h00, 1'b0);
    tx(8'h41, 1'b1, 8'h41, 1'b0);
    tx(8'h09, 1'b0, 8'h00, 1'b0);
    chk({7'h00, tabDiscarded}, 8'h00);
    cfg(1'b0, 1'b1);
    tx(8'h41, 1'b1, 8'h41, 1'b0);
    tx(8'h0E, 1'b0, 8'h00, 1'b0);
    chk({7'h00, shiftAlternate}, 8'h01);
    tx(8'h41, 1'b1, 8'h41, 1'b1);
    tx(8'h0F, 1'b0, 8'h00, 1'b0);
    tx(8'hC1, 1'b1, 8'h41, 1'b0);
    tx(8'h0E, 1'b0, 8'h00, 1'b0);
    @(posedge clk);
    subAlt <= 1'b1;
    tx(8'h61, 1'b1, 8'h80, 1'b1);
    tx(8'h66, 1'b1, 8'h85, 1'b1);
    tx(8'h67, 1'b1, 8'h67, 1'b1);
    @(posedge clk);
    subAlt <= 1'b0;
    dualSet <= 1'b1;
    tx(8'h09, 1'b0, 8'h00, 1'b0);
    chk({7'h00, tabDiscarded}, 8'h01);
    tx(8'h1B, 1'b0, 8'h00, 1'b0);
    tx(8'h33, 1'b0, 8'h00, 1'b0);
    chk({7'h00, tabDiscarded}, 8'h01);
    cfg(1'b1, 1'b0);
    tx(8'h41, 1'b1, 8'h41, 1'b0);
    tx(8'hC1, 1'b1, 8'h7F, 1'b0);
    tx(8'h8E, 1'b0, 8'h00, 1'b0);
    tx(8'h41, 1'b1, 8'h41, 1'b1);
    tx(8'h40, 1'b1, 8'h7F, 1'b0);
    cfg(1'b1, 1'b1);
    tx(8'hC1, 1'b1, 8'h41, 1'b0);
    tx(8'h41, 1'b1, 8'h7F, 1'b0);
    tx(8'h0E, 1'b0, 8'h00, 1'b0);
    tx(8'hC1, 1'b1, 8'h41, 1'b1);
    @(posedge clk);
    testRun <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({6'h00, glyphValid, glyphAlternate}, 8'h02);
    chk(glyphCode, 8'h22);
    cfg(1'b0, 1'b0);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({6'h00, glyphValid, glyphAlternate}, 8'h03);
    chk(glyphCode, 8'h22);
    // One full pass of 64 plus 31 glyphs later the same code must show again.
    repeat (95) @(posedge clk);
    @(negedge clk);
    chk(glyphCode, 8'h22);
    end_sim();
  end
endmodule : tb_top
